/* logic/interlock_logic_engine.sv */
/*
  Programmable Boolean interlock engine for one switchgear object, with an
  AHB-Lite register slave for mode, settings, program rows and indicators.
  Assumes synchronous inputs, a 20 MHz hclk, single-word AHB transfers.
*/
`timescale 1ns/1ps
module interlock_logic_engine #(
  parameter int unsigned SCAN_CYCLES = ilk_pkg::SCAN_CYCLES,
  parameter int unsigned NUM_TEMPS   = 20
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [1:0]  obj_status_1,
  input  wire logic [1:0]  obj_status_2,
  input  wire logic [1:0]  obj_status_3,
  input  wire logic [9:0]  bin_inputs,
  input  wire logic        key_remote,
  input  wire logic        open_cmd,
  input  wire logic        close_cmd,
  output logic             open_out,
  output logic             close_out,
  output logic             store_params_command,
  output logic             run_mode
);
  initial begin
    if (NUM_TEMPS != 20 || SCAN_CYCLES < 16) begin
      $error("interlock_logic_engine: unsupported parameter values");
    end
  end

  localparam int unsigned AW = 7;

  logic        mode_q;
  logic        ilk_en_q;
  logic        prog_written_q;
  logic        chk_err_q;
  logic        acc_q;
  logic        open_en_q;
  logic        close_en_q;
  logic [NUM_TEMPS-1:0] tmp_q;
  logic [AW-1:0]        pc_q;
  ilk_pkg::ev_state_t   st_q;
  logic [31:0] ind_q [ilk_pkg::IND_COUNT];

  logic        scan_tick;
  logic [ilk_pkg::INSTR_W-1:0] rd_instr;
  logic [ilk_pkg::INSTR_W-1:0] rd_instr_q;
  logic        mem_we;
  logic [AW-1:0] mem_waddr;
  logic [AW-1:0] mem_raddr;

  // AHB address phase capture
  logic        ap_valid_q;
  logic        ap_write_q;
  logic [11:0] ap_addr_q;
  logic        dp_rd_pending_q;
  logic        ahb_go;

  assign ahb_go = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q  <= 12'h000;
    end else if (hready) begin
      ap_valid_q <= ahb_go;
      ap_write_q <= hwrite;
      ap_addr_q  <= haddr[11:0];
    end
  end

  logic wr_now;
  logic in_prog;
  logic in_ind;
  logic [AW-1:0] prog_idx;
  logic [3:0]    ind_idx;

  assign wr_now   = ap_valid_q && ap_write_q;
  assign in_prog  = ap_addr_q >= ilk_pkg::OFS_PROG_BASE && ap_addr_q <= ilk_pkg::OFS_PROG_END;
  assign in_ind   = ap_addr_q[11:6] == ilk_pkg::OFS_IND_BASE[11:6];
  assign prog_idx = AW'((ap_addr_q - ilk_pkg::OFS_PROG_BASE) >> 2);
  assign ind_idx  = ap_addr_q[5:2];

  // Program edits only in program mode; run mode locks the list
  assign mem_we    = wr_now && in_prog && !mode_q;
  assign mem_waddr = prog_idx;
  // Bus reads look the row up in the address phase while st_q is EV_IDLE, so data is ready for the answer
  assign mem_raddr = (st_q != ilk_pkg::EV_IDLE) ? pc_q
                   : ahb_go ? AW'((haddr[11:0] - ilk_pkg::OFS_PROG_BASE) >> 2) : prog_idx;

  ilk_prog_mem #(
    .DEPTH (ilk_pkg::PROG_ROWS),
    .WIDTH (ilk_pkg::INSTR_W),
    .AW    (AW)
  ) u_mem (
    .hclk  (hclk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (hwdata[ilk_pkg::INSTR_W-1:0]),
    .raddr (mem_raddr),
    .rdata (rd_instr)
  );

  ilk_scan_timer #(
    .PERIOD (SCAN_CYCLES)
  ) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (scan_tick)
  );

  // Indicator configuration words; unconfigured ones read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < ilk_pkg::IND_COUNT; i++) begin
        ind_q[i] <= 32'h0000_0000;
      end
    end else if (wr_now && in_ind && !mode_q) begin
      ind_q[ind_idx] <= hwdata;
    end
  end

  logic run_req;
  assign run_req = wr_now && ap_addr_q == ilk_pkg::OFS_MODE && hwdata[0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ilk_en_q <= 1'b0;
    end else if (wr_now && ap_addr_q == ilk_pkg::OFS_ILK_EN) begin
      ilk_en_q <= hwdata[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_written_q <= 1'b0;
    end else if (mem_we) begin
      prog_written_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      store_params_command <= 1'b0;
    end else begin
      store_params_command <= wr_now && ap_addr_q == ilk_pkg::OFS_STORE && hwdata[0];
    end
  end

  // Operand decode
  logic [7:0] opd;
  logic [2:0] opc;
  logic       opd_val;
  logic       opd_ok;
  logic [1:0] ch_st;
  assign opd = rd_instr_q[7:0];
  assign opc = rd_instr_q[ilk_pkg::INSTR_W-1:ilk_pkg::OPC_LSB];

  always_comb begin
    ch_st   = 2'b00;
    opd_val = 1'b0;
    opd_ok  = 1'b1;
    if (opd >= ilk_pkg::OPD_CH_FIRST && opd <= ilk_pkg::OPD_CH_LAST) begin
      ch_st   = (opd == 8'h01) ? obj_status_1 : (opd == 8'h02) ? obj_status_2 : obj_status_3;
      opd_val = ch_st == ilk_pkg::ST_CLOSED;
    end else if (opd >= 8'(ilk_pkg::OPD_CH_FIRST + ilk_pkg::OPD_UNDEF_OFS)
                 && opd <= 8'(ilk_pkg::OPD_CH_LAST + ilk_pkg::OPD_UNDEF_OFS)) begin
      ch_st   = (opd == 8'h65) ? obj_status_1 : (opd == 8'h66) ? obj_status_2 : obj_status_3;
      opd_val = ch_st != ilk_pkg::ST_CLOSED && ch_st != ilk_pkg::ST_OPEN;
    end else if (opd >= 8'(ilk_pkg::OPD_CH_FIRST + ilk_pkg::OPD_OPEN_OFS)
                 && opd <= 8'(ilk_pkg::OPD_CH_LAST + ilk_pkg::OPD_OPEN_OFS)) begin
      ch_st   = (opd == 8'hc9) ? obj_status_1 : (opd == 8'hca) ? obj_status_2 : obj_status_3;
      opd_val = ch_st == ilk_pkg::ST_OPEN;
    end else if (opd >= ilk_pkg::OPD_BI_FIRST && opd <= ilk_pkg::OPD_BI_LAST) begin
      opd_val = bin_inputs[4'(opd - ilk_pkg::OPD_BI_FIRST)];
    end else if (opd == ilk_pkg::OPD_ZERO) begin
      opd_val = 1'b0;
    end else if (opd == ilk_pkg::OPD_ONE) begin
      opd_val = 1'b1;
    end else if (opd == ilk_pkg::OPD_KEY) begin
      opd_val = key_remote;
    end else if (opd >= ilk_pkg::OPD_TMP_FIRST && opd <= ilk_pkg::OPD_TMP_LAST) begin
      opd_val = tmp_q[5'(opd - ilk_pkg::OPD_TMP_FIRST)];
    end else begin
      opd_ok  = 1'b0;
    end
  end

  logic out_tgt_ok;
  assign out_tgt_ok = opd == ilk_pkg::OPD_OPEN_OUT || opd == ilk_pkg::OPD_CLOSE_OUT
                      || (opd >= ilk_pkg::OPD_TMP_FIRST && opd <= ilk_pkg::OPD_TMP_LAST);

  // Evaluation and syntax check sequencer
  logic last_row;
  assign last_row = pc_q == AW'(ilk_pkg::PROG_ROWS - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q       <= ilk_pkg::EV_IDLE;
      pc_q       <= '0;
      rd_instr_q <= '0;
      chk_err_q  <= 1'b0;
      mode_q     <= 1'b0;
    end else begin
      case (st_q)
        ilk_pkg::EV_IDLE: begin
          if (wr_now && ap_addr_q == ilk_pkg::OFS_MODE && !hwdata[0]) begin
            mode_q <= 1'b0;
          end else if (run_req && !mode_q && ilk_en_q && prog_written_q) begin
            pc_q      <= '0;
            chk_err_q <= 1'b0;
            st_q      <= ilk_pkg::EV_CHECK;
          end else if (mode_q && scan_tick) begin
            pc_q <= '0;
            st_q <= ilk_pkg::EV_FETCH;
          end
        end
        ilk_pkg::EV_FETCH: begin
          st_q <= ilk_pkg::EV_EXEC;
        end
        ilk_pkg::EV_EXEC: begin
          rd_instr_q <= rd_instr;
          st_q       <= ilk_pkg::EV_CHKX;
        end
        ilk_pkg::EV_CHKX: begin
          if (opc == ilk_pkg::OP_END || last_row) begin
            st_q <= ilk_pkg::EV_IDLE;
          end else begin
            pc_q <= pc_q + AW'(1);
            st_q <= ilk_pkg::EV_FETCH;
          end
        end
        ilk_pkg::EV_CHECK: begin
          rd_instr_q <= rd_instr;
          st_q       <= ilk_pkg::EV_CHECK;
          // Row data lags the row counter by two cycles through the memory and rd_instr_q
          if (pc_q > AW'(1)) begin
            if (opc == ilk_pkg::OP_END) begin
              mode_q <= !chk_err_q;
              st_q   <= ilk_pkg::EV_IDLE;
            end else if ((opc == ilk_pkg::OP_OUT && !out_tgt_ok)
                         || (opc != ilk_pkg::OP_OUT && !opd_ok)
                         || (pc_q == AW'(2) && opc != ilk_pkg::OP_LOAD
                             && opc != ilk_pkg::OP_LOADN)) begin
              chk_err_q <= 1'b1;
            end
          end
          if (pc_q == AW'(ilk_pkg::PROG_ROWS + 1) && opc != ilk_pkg::OP_END) begin
            chk_err_q <= 1'b1;
            st_q      <= ilk_pkg::EV_IDLE;
          end else begin
            pc_q <= pc_q + AW'(1);
          end
        end
        default: st_q <= ilk_pkg::EV_IDLE;
      endcase
      // A return to program mode must not be lost while a scan is running
      if (wr_now && ap_addr_q == ilk_pkg::OFS_MODE && !hwdata[0]) begin
        mode_q <= 1'b0;
        st_q   <= ilk_pkg::EV_IDLE;
      end
    end
  end

  // Accumulator and OUT targets; targets hold between scans
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q      <= 1'b0;
      open_en_q  <= 1'b0;
      close_en_q <= 1'b0;
      tmp_q      <= '0;
    end else if (!mode_q) begin
      open_en_q  <= 1'b0;
      close_en_q <= 1'b0;
    end else if (st_q == ilk_pkg::EV_CHKX) begin
      case (opc)
        ilk_pkg::OP_LOAD:  acc_q <= opd_val;
        ilk_pkg::OP_LOADN: acc_q <= !opd_val;
        ilk_pkg::OP_AND:   acc_q <= acc_q & opd_val;
        ilk_pkg::OP_ANDN:  acc_q <= acc_q & !opd_val;
        ilk_pkg::OP_OR:    acc_q <= acc_q | opd_val;
        ilk_pkg::OP_ORN:   acc_q <= acc_q | !opd_val;
        ilk_pkg::OP_OUT: begin
          if (opd == ilk_pkg::OPD_OPEN_OUT) begin
            open_en_q <= acc_q;
          end else if (opd == ilk_pkg::OPD_CLOSE_OUT) begin
            close_en_q <= acc_q;
          end else if (opd >= ilk_pkg::OPD_TMP_FIRST && opd <= ilk_pkg::OPD_TMP_LAST) begin
            tmp_q[5'(opd - ilk_pkg::OPD_TMP_FIRST)] <= acc_q;
          end
        end
        default: acc_q <= acc_q;
      endcase
    end
  end

  // Command gating, same path for local, serial and binary input commands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      open_out  <= 1'b0;
      close_out <= 1'b0;
      run_mode  <= 1'b0;
    end else begin
      open_out  <= open_cmd && (!ilk_en_q || open_en_q);
      close_out <= close_cmd && (!ilk_en_q || close_en_q);
      run_mode  <= mode_q;
    end
  end

  // Bus read data and response
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_rd_pending_q <= 1'b0;
      hrdata          <= 32'h0000_0000;
      hreadyout       <= 1'b1;
      hresp           <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (ahb_go && !hwrite && hreadyout) begin
        dp_rd_pending_q <= 1'b1;
        hreadyout       <= 1'b0;
      end else if (dp_rd_pending_q) begin
        dp_rd_pending_q <= 1'b0;
        hreadyout       <= 1'b1;
        if (in_prog) begin
          hrdata <= {20'h00000, rd_instr};
        end else if (in_ind) begin
          hrdata <= ind_q[ind_idx];
        end else begin
          case (ap_addr_q)
            ilk_pkg::OFS_MODE:   hrdata <= {31'h0, mode_q};
            ilk_pkg::OFS_ILK_EN: hrdata <= {31'h0, ilk_en_q};
            ilk_pkg::OFS_STATUS: hrdata <= {26'h0, chk_err_q, prog_written_q,
                                            open_en_q, close_en_q, acc_q, mode_q};
            ilk_pkg::OFS_INPUTS: hrdata <= {15'h0000, key_remote, obj_status_3,
                                            obj_status_2, obj_status_1, bin_inputs};
            ilk_pkg::OFS_TEMPS:  hrdata <= {12'h000, tmp_q};
            default:             hrdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end
endmodule

/* logic/ilk_pkg.sv */
/*
  Constants shared by the interlock logic engine: register map, instruction
  encoding, operand codes, scan timing.
  Assumes a 20 MHz system clock and an AHB-Lite master with 32-bit data.
*/
package ilk_pkg;
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned SCAN_MS        = 20;
  localparam int unsigned SCAN_CYCLES    = CLK_HZ / 1000 * SCAN_MS;
  localparam int unsigned PROG_ROWS      = 101;
  localparam int unsigned IND_COUNT      = 16;

  // Register byte offsets
  localparam logic [11:0] OFS_MODE       = 12'h000;
  localparam logic [11:0] OFS_ILK_EN     = 12'h004;
  localparam logic [11:0] OFS_STORE      = 12'h008;
  localparam logic [11:0] OFS_STATUS     = 12'h00c;
  localparam logic [11:0] OFS_INPUTS     = 12'h010;
  localparam logic [11:0] OFS_TEMPS      = 12'h014;
  localparam logic [11:0] OFS_IND_BASE   = 12'h100;
  localparam logic [11:0] OFS_PROG_BASE  = 12'h400;
  localparam logic [11:0] OFS_PROG_END   = 12'h594;

  // Instruction word: opcode in [11:9], operand in [7:0]
  localparam int unsigned OPC_LSB        = 9;
  localparam int unsigned INSTR_W        = 12;
  localparam logic [2:0] OP_END          = 3'h0;
  localparam logic [2:0] OP_LOAD         = 3'h1;
  localparam logic [2:0] OP_LOADN        = 3'h2;
  localparam logic [2:0] OP_AND          = 3'h3;
  localparam logic [2:0] OP_ANDN         = 3'h4;
  localparam logic [2:0] OP_OR           = 3'h5;
  localparam logic [2:0] OP_ORN          = 3'h6;
  localparam logic [2:0] OP_OUT          = 3'h7;

  // Operand codes
  localparam logic [7:0] OPD_CH_FIRST    = 8'h01;
  localparam logic [7:0] OPD_CH_LAST     = 8'h03;
  localparam logic [7:0] OPD_UNDEF_OFS   = 8'h64;
  localparam logic [7:0] OPD_OPEN_OFS    = 8'hc8;
  localparam logic [7:0] OPD_BI_FIRST    = 8'h04;
  localparam logic [7:0] OPD_BI_LAST     = 8'h0d;
  localparam logic [7:0] OPD_OPEN_OUT    = 8'h14;
  localparam logic [7:0] OPD_CLOSE_OUT   = 8'h15;
  localparam logic [7:0] OPD_ZERO        = 8'h3c;
  localparam logic [7:0] OPD_ONE         = 8'h3d;
  localparam logic [7:0] OPD_KEY         = 8'h3e;
  localparam logic [7:0] OPD_TMP_FIRST   = 8'h46;
  localparam logic [7:0] OPD_TMP_LAST    = 8'h59;

  // Status channel encoding {open, closed}: 2'b01 closed, 2'b10 open, else undefined
  localparam logic [1:0] ST_CLOSED       = 2'b01;
  localparam logic [1:0] ST_OPEN         = 2'b10;

  typedef enum logic [2:0] {
    EV_IDLE  = 3'b000,
    EV_FETCH = 3'b001,
    EV_EXEC  = 3'b011,
    EV_CHECK = 3'b010,
    EV_CHKX  = 3'b110
  } ev_state_t;
endpackage

/* logic/ilk_prog_mem.sv */
/*
  Program row memory: one write port, one read port with registered data.
  Assumes a single clock; rows reset to END by the caller rewriting them.
*/
`timescale 1ns/1ps
module ilk_prog_mem #(
  parameter int unsigned DEPTH = 101,
  parameter int unsigned WIDTH = 12,
  parameter int unsigned AW    = 7
) (
  input  wire logic             hclk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  initial begin
    if (DEPTH > (1 << AW)) begin
      $error("ilk_prog_mem: DEPTH does not fit AW");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

/* logic/ilk_scan_timer.sv */
/*
  Scan period divider: emits a one-cycle tick every PERIOD clocks.
  Assumes hclk and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module ilk_scan_timer #(
  parameter int unsigned PERIOD = 400_000
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      tick
);
  initial begin
    if (PERIOD < 2) begin
      $error("ilk_scan_timer: PERIOD too small");
    end
  end

  logic [31:0] cnt_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 32'h0000_0000;
      tick  <= 1'b0;
    end else if (cnt_q == 32'(PERIOD - 1)) begin
      cnt_q <= 32'h0000_0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
      tick  <= 1'b0;
    end
  end
endmodule

/* verification/ilk_checker.sv */
/*
  Port checker for the interlock engine, bound into the top module.
  Assumes the bus hready is the engine's own hreadyout.
*/
`timescale 1ns/1ps
module ilk_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        open_cmd,
  input wire logic        close_cmd,
  input wire logic        open_out,
  input wire logic        close_out,
  input wire logic        store_params_command,
  input wire logic        run_mode
);
  logic        aw_q;
  logic [11:0] aa_q;
  logic        ilk_q;
  logic        req_q;
  logic        dw;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Data phase of a write, so setting shadows follow the bus exactly
  assign dw = aw_q && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aw_q <= 1'b0;
      aa_q <= 12'h000;
    end else if (hready) begin
      aw_q <= hsel && htrans[1] && hwrite;
      aa_q <= haddr[11:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ilk_q <= 1'b0;
      req_q <= 1'b0;
    end else begin
      if (dw && aa_q == ilk_pkg::OFS_ILK_EN) ilk_q <= hwdata[0];
      if (dw && aa_q == ilk_pkg::OFS_MODE) req_q <= hwdata[0];
    end
  end

  AST_OPEN_CMD: assert property (open_out |-> $past(open_cmd))
    else $error("open output without open command");
  AST_CLOSE_CMD: assert property (close_out |-> $past(close_cmd))
    else $error("close output without close command");
  AST_STORE_PULSE: assert property (store_params_command |=> !store_params_command)
    else $error("store pulse longer than one cycle");
  AST_STORE_WRITE: assert property ((dw && aa_q == ilk_pkg::OFS_STORE && hwdata[0])
    |-> ##[0:2] store_params_command) else $error("store write gave no pulse");
  AST_PROG_INHIBIT: assert property ((!run_mode && $past(!run_mode) && ilk_q
    && $past(ilk_q)) |-> !open_out && !close_out) else $error("control in program mode");
  AST_BYPASS: assert property ((!ilk_q && $past(!ilk_q)) |-> open_out == $past(open_cmd)
    && close_out == $past(close_cmd)) else $error("ungated command not passed");
  AST_RUN_NEEDS_ILK: assert property ($rose(run_mode) |-> ilk_q)
    else $error("run mode with interlock disabled");
  AST_RUN_NEEDS_REQ: assert property ($rose(run_mode) |-> req_q)
    else $error("run mode without request");
  AST_READ_WAIT: assert property ((hsel && hready && htrans[1] && !hwrite)
    |=> !hreadyout ##1 hreadyout) else $error("read answer timing wrong");
endmodule

bind interlock_logic_engine ilk_checker ilk_checker_i (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .open_cmd, .close_cmd, .open_out,
  .close_out, .store_params_command, .run_mode);

/* verification/ilk_obj_model.sv */
/*
  Auxiliary contacts of one switchgear object, as seen on a status channel.
  Assumes pos: 0 open, 1 closed, 2 in travel, 3 contacts faulty.
*/
`timescale 1ns/1ps
module ilk_obj_model (
  input  wire logic [1:0] pos,
  output logic      [1:0] status
);
  // In travel neither contact makes; a fault shows both, so both read undefined
  always_comb begin
    case (pos)
      2'h0:    status = ilk_pkg::ST_OPEN;
      2'h1:    status = ilk_pkg::ST_CLOSED;
      2'h2:    status = 2'b00;
      default: status = 2'b11;
    endcase
  end
endmodule

/* verification/testbench.sv */
/*
  Self-checking bench: AHB-Lite master tasks, object models on the status
  channels, program load, scan and gating checks. Assumes SCAN shortened.
*/
`timescale 1ns/1ps
module testbench;
  localparam int unsigned SCAN = 128;
  logic        hclk, hresetn, hsel, hwrite, key_remote, open_cmd, close_cmd, seen;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans, pos_1, pos_2, pos_3, st_1, st_2, st_3;
  logic [2:0]  hsize;
  logic [9:0]  bin_inputs;
  logic        hreadyout, hresp, open_out, close_out, store_params_command, run_mode;
  logic        ec, eo, et;
  logic [31:0] pg [14];
  logic [16:0] vt [4];
  int          bad_count, samples_checked, cycles;

  interlock_logic_engine #(.SCAN_CYCLES(SCAN)) interlock_logic_engine_i (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .obj_status_1(st_1), .obj_status_2(st_2), .obj_status_3(st_3),
    .bin_inputs, .key_remote, .open_cmd, .close_cmd, .open_out, .close_out,
    .store_params_command, .run_mode);
  ilk_obj_model obj_1_i (.pos(pos_1), .status(st_1));
  ilk_obj_model obj_2_i (.pos(pos_2), .status(st_2));
  ilk_obj_model obj_3_i (.pos(pos_3), .status(st_3));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h00000, a};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  task rd(input logic [11:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask

  function automatic logic [31:0] ins(input logic [2:0] op, input logic [7:0] opd);
    return {20'h00000, op, 1'b0, opd};
  endfunction

  // Every row is written because the row memory has no reset
  task load(input int n);
    for (int r = 0; r < 101; r++)
      wr(ilk_pkg::OFS_PROG_BASE + 12'(4 * r), r < n ? pg[r] : ins(ilk_pkg::OP_END, 8'h00));
  endtask

  task wait_run();
    for (int i = 0; i < 400 && run_mode !== 1'b1; i++) @(posedge hclk);
  endtask

  task cmd(input logic [1:0] c, input logic [1:0] e);
    {open_cmd, close_cmd} <= c;
    repeat (2) @(posedge hclk);
    chk({open_out, close_out}, e);
    {open_cmd, close_cmd} <= 2'b00;
    @(posedge hclk);
  endtask

  initial begin
    {hresetn, hsel, hwrite, key_remote, open_cmd, close_cmd} = 6'h00;
    {haddr, hwdata, htrans, hsize, bin_inputs} = '0;
    {pos_1, pos_2, pos_3} = 6'h00;
    bad_count = 0;
    samples_checked = 0;
    cycles = 0;
    vt[0] = {2'h1, 2'h2, 2'h0, 10'h001, 1'b0};
    vt[1] = {2'h3, 2'h1, 2'h1, 10'h000, 1'b1};
    vt[2] = {2'h0, 2'h3, 2'h1, 10'h001, 1'b1};
    vt[3] = {2'h1, 2'h2, 2'h1, 10'h200, 1'b0};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ilk_pkg::OFS_STATUS); chk(d, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    rd(ilk_pkg::OFS_IND_BASE); chk(d, 32'h0);
    rd(ilk_pkg::OFS_IND_BASE + 12'h03c); chk(d, 32'h0);
    rd(12'h800); chk(d, 32'h0);
    cmd(2'b11, 2'b11);
    wr(ilk_pkg::OFS_MODE, 32'h1); wait_run(); chk(run_mode, 1'b0);
    wr(ilk_pkg::OFS_ILK_EN, 32'h1); cmd(2'b11, 2'b00);
    wr(ilk_pkg::OFS_MODE, 32'h1); wait_run(); chk(run_mode, 1'b0);
    pg[0] = ins(ilk_pkg::OP_LOAD, ilk_pkg::OPD_ONE);
    pg[1] = ins(ilk_pkg::OP_OUT, ilk_pkg::OPD_ZERO);
    pg[2] = ins(ilk_pkg::OP_END, 8'h00);
    load(3);
    wr(ilk_pkg::OFS_MODE, 32'h1); wait_run(); chk(run_mode, 1'b0);
    rd(ilk_pkg::OFS_STATUS); chk(d[5], 1'b1);
    pg[1] = ins(ilk_pkg::OP_AND, 8'hcb);
    pg[2] = ins(ilk_pkg::OP_OR, 8'hc9);
    pg[3] = ins(ilk_pkg::OP_OUT, ilk_pkg::OPD_CLOSE_OUT);
    pg[4] = ins(ilk_pkg::OP_LOADN, ilk_pkg::OPD_KEY);
    pg[5] = ins(ilk_pkg::OP_ANDN, ilk_pkg::OPD_ZERO);
    pg[6] = ins(ilk_pkg::OP_ORN, ilk_pkg::OPD_ONE);
    pg[7] = ins(ilk_pkg::OP_AND, ilk_pkg::OPD_BI_FIRST);
    pg[8] = ins(ilk_pkg::OP_OUT, ilk_pkg::OPD_TMP_FIRST);
    pg[9] = ins(ilk_pkg::OP_LOAD, ilk_pkg::OPD_TMP_FIRST);
    pg[10] = ins(ilk_pkg::OP_AND, 8'h66);
    pg[11] = ins(ilk_pkg::OP_OR, ilk_pkg::OPD_BI_LAST);
    pg[12] = ins(ilk_pkg::OP_OUT, ilk_pkg::OPD_OPEN_OUT);
    pg[13] = ins(ilk_pkg::OP_END, 8'h00);
    pg[0] = ins(ilk_pkg::OP_LOAD, ilk_pkg::OPD_CH_FIRST);
    load(14);
    wr(ilk_pkg::OFS_MODE, 32'h1); wait_run(); chk(run_mode, 1'b1);
    // A dropped edit must leave the open enable row in place
    wr(ilk_pkg::OFS_PROG_BASE + 12'h030, ins(ilk_pkg::OP_END, 8'h00));
    for (int v = 0; v < 4; v++) begin
      {pos_1, pos_2, pos_3, bin_inputs, key_remote} <= vt[v];
      repeat (3 * SCAN) @(posedge hclk);
      ec = (pos_1 == 2'h1 && pos_3 == 2'h0) || pos_1 == 2'h0;
      et = !key_remote && bin_inputs[0];
      eo = (et && pos_2 >= 2'h2) || bin_inputs[9];
      rd(ilk_pkg::OFS_STATUS); chk(d[3:2], {eo, ec});
      rd(ilk_pkg::OFS_TEMPS); chk(d[0], et);
      cmd(2'b11, {eo, ec});
    end
    wr(ilk_pkg::OFS_STORE, 32'h1);
    seen = 1'b0;
    repeat (4) begin
      @(posedge hclk);
      seen = seen | store_params_command;
    end
    chk(seen, 1'b1);
    wr(ilk_pkg::OFS_MODE, 32'h0);
    repeat (4) @(posedge hclk);
    chk(run_mode, 1'b0);
    cmd(2'b11, 2'b00);
    give_verdict();
  end
endmodule
